// ### hw/i2c_read_target.sv
// i2c target end: pointer write, byte write, burst read, bus watchdog
// assumes the link resolves open-drain levels and the host owns scl
// Operation
// - read is pointer write, restart, read address
// - after read address ack, device drives data
// - host acks each byte it wants continued
// - host nack makes device release data line
// - pointer advances by one per byte
// - each read starts from last written pointer
// - pointer starts at zero before any write
// - watchdog resets interface on device bus lock
// - config enable bit switches watchdog on
// - config select bit picks 1 or 50 ms
// - host idles 2 us after writes, normal
// - host idles 450 us after writes, suspend
// - address select pin, chip select picks protocol
// - shared data pin is bidirectional i2c data
// - address 0x68 select low, 0x69 high
// - write is address, pointer, one data byte
// - stop after a start with no clock between is ignored
`timescale 1ns/1ns
`include "i2c_target_map.svh"
module i2c_read_target #(
  parameter int WDT_SHORT_CYC = `WDT_SHORT_CYC,
  parameter int WDT_LONG_CYC = `WDT_LONG_CYC
) (
  input wire logic sys_clk_i, // system clock
  input wire logic rst_i, // synchronous reset, high
  i2c_link_if.device link, // i2c bus
  input wire logic address_select_output_pin_i, // target address select
  input wire logic protocol_select_chip_select_pin_i, // high selects i2c
  input wire logic load_wr_i, // sensor side register load
  input wire logic [7:0] load_addr_i, // load address
  input wire logic [7:0] load_data_i, // load data
  output logic reg_wr_o, // bus wrote a register, pulse
  output logic [7:0] reg_wr_addr_o, // written register
  output logic [7:0] reg_wr_data_o, // written value
  output logic wdt_en_o, // watchdog enabled
  output logic wdt_sel_o, // long watchdog period selected
  output logic wdt_reset_o, // watchdog fired, pulse
  output logic busy_o // transaction in progress
);
  localparam logic [`WDT_CNT_W-1:0] SHORT_LIM =
    `WDT_CNT_W'(WDT_SHORT_CYC - 1);
  localparam logic [`WDT_CNT_W-1:0] LONG_LIM =
    `WDT_CNT_W'(WDT_LONG_CYC - 1);

  i2c_target_pkg::dev_state_t state;
  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;
  logic asel_m, asel_s;
  logic psel_m, psel_s;
  logic scl_rise, scl_fall, start_ev, stop_ev;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] tx;
  logic [7:0] ptr;
  logic [7:0] base_ptr;
  logic rw;
  logic host_ack;
  logic clk_seen;
  logic pull;
  logic [7:0] nonvolatile_interface_config;
  logic [7:0] mem [0:255];
  logic [7:0] rd_byte;
  logic [6:0] own_addr;
  logic [`WDT_CNT_W-1:0] wdt_cnt;
  logic wdt_fire;

  // pins and bus lines are asynchronous to sys_clk_i
  always_ff @(posedge sys_clk_i) begin
    scl_m <= link.scl_line;
    scl_s <= scl_m;
    scl_d <= scl_s;
    sda_m <= link.sda_line;
    sda_s <= sda_m;
    sda_d <= sda_s;
    asel_m <= address_select_output_pin_i;
    asel_s <= asel_m;
    psel_m <= protocol_select_chip_select_pin_i;
    psel_s <= psel_m;
  end

  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_ev = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_ev = scl_s & scl_d & ~sda_d & sda_s;

  assign own_addr = asel_s ? `TGT_ADDR_HIGH : `TGT_ADDR_LOW;

  assign rd_byte = (ptr == `NONVOLATILE_INTERFACE_CONFIG_OFFSET) ?
    nonvolatile_interface_config : mem[ptr];

  assign link.sda_dev_o = 1'b0;
  assign link.sda_dev_oe = pull;

  always_ff @(posedge sys_clk_i) begin
    reg_wr_o <= 1'b0;
    if (rst_i) begin
      state <= i2c_target_pkg::DEV_IDLE;
      pull <= 1'b0;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      tx <= 8'h00;
      rw <= 1'b0;
      host_ack <= 1'b0;
      clk_seen <= 1'b0;
      ptr <= `PTR_RESET;
      base_ptr <= `PTR_RESET;
      reg_wr_addr_o <= 8'h00;
      reg_wr_data_o <= 8'h00;
    end else if (!psel_s || wdt_fire) begin
      state <= i2c_target_pkg::DEV_IDLE;
      pull <= 1'b0;
      bit_cnt <= 4'h0;
      clk_seen <= 1'b0;
    end else if (start_ev) begin
      state <= i2c_target_pkg::DEV_ADDR;
      pull <= 1'b0;
      bit_cnt <= 4'h0;
      clk_seen <= 1'b0;
      ptr <= base_ptr;
    // stop needs a clock since start
    end else if (stop_ev && clk_seen) begin
      state <= i2c_target_pkg::DEV_IDLE;
      pull <= 1'b0;
    end else if (scl_rise) begin
      unique case (state)
        i2c_target_pkg::DEV_ADDR,
        i2c_target_pkg::DEV_PTR,
        i2c_target_pkg::DEV_WDATA: begin
          shift <= {shift[6:0], sda_s};
          bit_cnt <= bit_cnt + 4'h1;
        end
        i2c_target_pkg::DEV_RDATA: begin
          bit_cnt <= bit_cnt + 4'h1;
        end
        i2c_target_pkg::DEV_RACK: begin
          host_ack <= ~sda_s;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      clk_seen <= 1'b1;
      unique case (state)
        i2c_target_pkg::DEV_ADDR: begin
          if (bit_cnt == 4'h8) begin
            if (shift[7:1] == own_addr) begin
              state <= i2c_target_pkg::DEV_ADDR_ACK;
              pull <= 1'b1;
              rw <= shift[0];
            end else begin
              state <= i2c_target_pkg::DEV_IDLE;
            end
          end
        end
        // direction bit picks read or write
        i2c_target_pkg::DEV_ADDR_ACK: begin
          bit_cnt <= 4'h0;
          if (rw) begin
            state <= i2c_target_pkg::DEV_RDATA;
            tx <= {rd_byte[6:0], 1'b0};
            pull <= ~rd_byte[7];
            ptr <= ptr + 8'h01;
          end else begin
            state <= i2c_target_pkg::DEV_PTR;
            pull <= 1'b0;
          end
        end
        i2c_target_pkg::DEV_PTR: begin
          if (bit_cnt == 4'h8) begin
            state <= i2c_target_pkg::DEV_PTR_ACK;
            pull <= 1'b1;
            ptr <= shift;
            base_ptr <= shift;
          end
        end
        i2c_target_pkg::DEV_PTR_ACK: begin
          state <= i2c_target_pkg::DEV_WDATA;
          pull <= 1'b0;
          bit_cnt <= 4'h0;
        end
        i2c_target_pkg::DEV_WDATA: begin
          if (bit_cnt == 4'h8) begin
            state <= i2c_target_pkg::DEV_WDATA_ACK;
            pull <= 1'b1;
            reg_wr_o <= 1'b1;
            reg_wr_addr_o <= ptr;
            reg_wr_data_o <= shift;
            ptr <= ptr + 8'h01;
          end
        end
        // further bytes before stop are left unacknowledged
        i2c_target_pkg::DEV_WDATA_ACK: begin
          state <= i2c_target_pkg::DEV_IDLE;
          pull <= 1'b0;
        end
        i2c_target_pkg::DEV_RDATA: begin
          if (bit_cnt == 4'h8) begin
            state <= i2c_target_pkg::DEV_RACK;
            pull <= 1'b0;
          end else begin
            pull <= ~tx[7];
            tx <= {tx[6:0], 1'b0};
          end
        end
        i2c_target_pkg::DEV_RACK: begin
          bit_cnt <= 4'h0;
          if (host_ack) begin
            state <= i2c_target_pkg::DEV_RDATA;
            tx <= {rd_byte[6:0], 1'b0};
            pull <= ~rd_byte[7];
            ptr <= ptr + 8'h01;
          end else begin
            state <= i2c_target_pkg::DEV_IDLE;
            pull <= 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // bus write wins over a sensor load in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (reg_wr_o) begin
      mem[reg_wr_addr_o] <= reg_wr_data_o;
    end else if (load_wr_i) begin
      mem[load_addr_i] <= load_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      nonvolatile_interface_config <= `NONVOLATILE_INTERFACE_CONFIG_RESET;
    end else if (reg_wr_o && reg_wr_addr_o == `NONVOLATILE_INTERFACE_CONFIG_OFFSET) begin
      nonvolatile_interface_config <= reg_wr_data_o;
    end
  end

  assign wdt_en_o = nonvolatile_interface_config[`NV_WDT_EN_BIT];
  assign wdt_sel_o = nonvolatile_interface_config[`NV_WDT_SEL_BIT];

  // restart on scl edges and release
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !wdt_en_o || !pull || scl_rise || scl_fall || wdt_fire) begin
      wdt_cnt <= '0;
    end else begin
      wdt_cnt <= wdt_cnt + `WDT_CNT_W'(1);
    end
  end

  // fire after held low a full period
  assign wdt_fire = wdt_en_o && pull &&
    (wdt_cnt == (wdt_sel_o ? LONG_LIM : SHORT_LIM));
  assign wdt_reset_o = wdt_fire;
  assign busy_o = (state != i2c_target_pkg::DEV_IDLE);

endmodule : i2c_read_target

// ### include/i2c_target_map.svh
// register offsets, field positions, reset values and timing counts for
// the sensor i2c read target and its host
// assumes a 20 mhz system clock shared by both ends
`ifndef I2C_TARGET_MAP_SVH
`define I2C_TARGET_MAP_SVH

`define TGT_ADDR_LOW 7'h68
`define TGT_ADDR_HIGH 7'h69
`define NONVOLATILE_INTERFACE_CONFIG_OFFSET 8'h70
`define NONVOLATILE_INTERFACE_CONFIG_RESET 8'h00
`define NV_WDT_EN_BIT 0
`define NV_WDT_SEL_BIT 1
`define PTR_RESET 8'h00

`define CLK_MHZ 20
`define WDT_SHORT_MS 1
`define WDT_LONG_MS 50
`define WDT_SHORT_CYC (`WDT_SHORT_MS * `CLK_MHZ * 1000)
`define WDT_LONG_CYC (`WDT_LONG_MS * `CLK_MHZ * 1000)
`define WDT_CNT_W 20

`define IDLE_NORMAL_US 2
`define IDLE_SUSPEND_US 450
`define IDLE_NORMAL_CYC (`IDLE_NORMAL_US * `CLK_MHZ)
`define IDLE_SUSPEND_CYC (`IDLE_SUSPEND_US * `CLK_MHZ)
`define IDLE_CNT_W 14

`define HOST_QTR_CYC 13

`endif

// ### include/i2c_target_pkg.sv
// state types for the i2c read target and its host
// assumes nothing beyond a systemverilog compiler
package i2c_target_pkg;

  typedef enum logic [3:0] {
    DEV_IDLE,
    DEV_ADDR,
    DEV_ADDR_ACK,
    DEV_PTR,
    DEV_PTR_ACK,
    DEV_WDATA,
    DEV_WDATA_ACK,
    DEV_RDATA,
    DEV_RACK
  } dev_state_t;

  typedef enum logic [2:0] {
    HOST_IDLE,
    HOST_START,
    HOST_BYTE,
    HOST_STOP,
    HOST_GAP
  } host_state_t;

endpackage : i2c_target_pkg

// ### include/i2c_link_if.sv
// open-drain i2c link joining host and target
// assumes pull-ups: a line is low only while some end enables a low drive
`timescale 1ns/1ns
interface i2c_link_if;
  logic scl_o;
  logic scl_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic scl_line;
  logic sda_line;

  assign scl_line = ~(scl_oe & ~scl_o);
  assign sda_line = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));

  modport device (
    input scl_line,
    input sda_line,
    output sda_dev_o,
    output sda_dev_oe
  );

  modport host (
    input scl_line,
    input sda_line,
    output scl_o,
    output scl_oe,
    output sda_host_o,
    output sda_host_oe
  );
endinterface : i2c_link_if

// ### hw/i2c_read_host.sv
// i2c host end: byte write, pointer-then-burst read
// assumes the target on the link and a user issuing one command at a time
`timescale 1ns/1ns
`include "i2c_target_map.svh"
module i2c_read_host #(
  parameter int QTR_CYC = `HOST_QTR_CYC,
  parameter int IDLE_NORMAL_CYC = `IDLE_NORMAL_CYC,
  parameter int IDLE_SUSPEND_CYC = `IDLE_SUSPEND_CYC
) (
  input wire logic sys_clk_i, // system clock
  input wire logic rst_i, // synchronous reset, high
  i2c_link_if.host link, // i2c bus
  input wire logic suspend_i, // target in suspend mode
  input wire logic cmd_valid_i, // command request
  output logic cmd_ready_o, // host idle, takes command
  input wire logic cmd_read_i, // 1 burst read, 0 byte write
  input wire logic [6:0] cmd_target_i, // target address
  input wire logic [7:0] cmd_ptr_i, // register pointer
  input wire logic [7:0] cmd_wdata_i, // write data
  input wire logic [7:0] cmd_len_i, // read byte count, 0 as 1
  output logic rd_valid_o, // read byte ready, pulse
  output logic [7:0] rd_data_o, // read byte
  output logic done_o, // command finished, pulse
  output logic nack_o // target refused, with done
);
  localparam logic [7:0] QTR_LIM = 8'(QTR_CYC - 1);
  localparam logic [`IDLE_CNT_W-1:0] GAP_N = `IDLE_CNT_W'(IDLE_NORMAL_CYC - 1);
  localparam logic [`IDLE_CNT_W-1:0] GAP_S =
    `IDLE_CNT_W'(IDLE_SUSPEND_CYC - 1);

  i2c_target_pkg::host_state_t state;
  logic [7:0] qcnt;
  logic tick;
  logic [1:0] ph;
  logic [3:0] bit_idx;
  logic [2:0] stage;
  logic [7:0] txb, rxb, remaining, ptr_q, wdata_q;
  logic [6:0] tgt_q;
  logic is_read, got_ack, err;
  logic scl_lvl, sda_lvl;
  logic sda_m, sda_s;
  logic [`IDLE_CNT_W-1:0] gap_cnt;

  always_ff @(posedge sys_clk_i) begin
    sda_m <= link.sda_line;
    sda_s <= sda_m;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || qcnt == QTR_LIM) begin
      qcnt <= 8'h00;
    end else begin
      qcnt <= qcnt + 8'h01;
    end
  end
  assign tick = (qcnt == QTR_LIM);

  assign link.scl_o = 1'b0;
  assign link.scl_oe = ~scl_lvl;
  assign link.sda_host_o = 1'b0;
  assign link.sda_host_oe = ~sda_lvl;
  assign cmd_ready_o = (state == i2c_target_pkg::HOST_IDLE);

  always_ff @(posedge sys_clk_i) begin
    rd_valid_o <= 1'b0;
    done_o <= 1'b0;
    if (rst_i) begin
      state <= i2c_target_pkg::HOST_IDLE;
      ph <= 2'h0;
      bit_idx <= 4'h0;
      stage <= 3'h0;
      txb <= 8'h00;
      rxb <= 8'h00;
      remaining <= 8'h00;
      ptr_q <= 8'h00;
      wdata_q <= 8'h00;
      tgt_q <= 7'h00;
      is_read <= 1'b0;
      got_ack <= 1'b0;
      err <= 1'b0;
      scl_lvl <= 1'b1;
      sda_lvl <= 1'b1;
      gap_cnt <= '0;
      rd_data_o <= 8'h00;
      nack_o <= 1'b0;
    end else if (state == i2c_target_pkg::HOST_IDLE) begin
      if (cmd_valid_i) begin
        state <= i2c_target_pkg::HOST_START;
        ph <= 2'h0;
        stage <= 3'h0;
        is_read <= cmd_read_i;
        tgt_q <= cmd_target_i;
        ptr_q <= cmd_ptr_i;
        wdata_q <= cmd_wdata_i;
        remaining <= (cmd_len_i == 8'h00) ? 8'h01 : cmd_len_i;
        err <= 1'b0;
      end
    end else if (state == i2c_target_pkg::HOST_GAP) begin
      if (gap_cnt == (suspend_i ? GAP_S : GAP_N)) begin
        state <= i2c_target_pkg::HOST_IDLE;
        done_o <= 1'b1;
        nack_o <= err;
      end else begin
        gap_cnt <= gap_cnt + `IDLE_CNT_W'(1);
      end
    end else if (tick) begin
      ph <= ph + 2'h1;
      unique case (state)
        // also serves as repeated start: sda rises while scl low
        i2c_target_pkg::HOST_START: begin
          case (ph)
            2'h0: sda_lvl <= 1'b1;
            2'h1: scl_lvl <= 1'b1;
            2'h2: sda_lvl <= 1'b0;
            default: begin
              scl_lvl <= 1'b0;
              state <= i2c_target_pkg::HOST_BYTE;
              bit_idx <= 4'h0;
              txb <= {tgt_q, stage == 3'h3};
            end
          endcase
        end
        i2c_target_pkg::HOST_BYTE: begin
          case (ph)
            2'h0: begin
              if (bit_idx == 4'h8) begin
                // ack all but the last byte
                sda_lvl <= (stage == 3'h4) ? (remaining == 8'h01) : 1'b1;
              end else begin
                sda_lvl <= (stage == 3'h4) ? 1'b1 : txb[7];
              end
            end
            2'h1: scl_lvl <= 1'b1;
            2'h2: begin
              if (bit_idx == 4'h8) begin
                got_ack <= ~sda_s;
              end else begin
                rxb <= {rxb[6:0], sda_s};
              end
            end
            default: begin
              scl_lvl <= 1'b0;
              bit_idx <= bit_idx + 4'h1;
              txb <= {txb[6:0], 1'b0};
              if (bit_idx == 4'h8) begin
                bit_idx <= 4'h0;
                if (stage == 3'h4) begin
                  rd_valid_o <= 1'b1;
                  rd_data_o <= rxb;
                  remaining <= remaining - 8'h01;
                  if (remaining == 8'h01) begin
                    state <= i2c_target_pkg::HOST_STOP;
                  end
                end else if (!got_ack) begin
                  err <= 1'b1;
                  state <= i2c_target_pkg::HOST_STOP;
                end else if (stage == 3'h0) begin
                  stage <= 3'h1;
                  txb <= ptr_q;
                end else if (stage == 3'h1 && is_read) begin
                  stage <= 3'h3;
                  state <= i2c_target_pkg::HOST_START;
                end else if (stage == 3'h1) begin
                  stage <= 3'h2;
                  txb <= wdata_q;
                end else if (stage == 3'h3) begin
                  stage <= 3'h4;
                end else begin
                  state <= i2c_target_pkg::HOST_STOP;
                end
              end
            end
          endcase
        end
        i2c_target_pkg::HOST_STOP: begin
          case (ph)
            2'h0: sda_lvl <= 1'b0;
            2'h1: scl_lvl <= 1'b1;
            2'h2: sda_lvl <= 1'b1;
            default: begin
              state <= i2c_target_pkg::HOST_GAP;
              gap_cnt <= '0;
            end
          endcase
        end
        default: begin
        end
      endcase
    end
  end

endmodule : i2c_read_host

// ### tb/i2c_link_properties.sv
// concurrent checks on the link between host and target
// assumes the resolved line levels and the drive enables of both ends
`timescale 1ns/1ns
module i2c_link_properties (
  input wire logic sys_clk_i, // system clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic scl_o, // host clock level
  input wire logic scl_oe, // host clock drive
  input wire logic sda_host_oe, // host data drive
  input wire logic sda_dev_o, // device data level
  input wire logic sda_dev_oe, // device data drive
  input wire logic scl_line, // resolved clock
  input wire logic sda_line // resolved data
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_start;
    scl_line && $past(scl_line) && $fell(sda_line);
  endsequence
  sequence s_stop;
    scl_line && $past(scl_line) && $rose(sda_line);
  endsequence

  chk_start_dev_idle: assert property (s_start |-> !sda_dev_oe)
    else $error("device drives data at a start");
  chk_stop_dev_free: assert property (s_stop |-> !sda_dev_oe)
    else $error("device drives data at a stop");
  chk_dev_pull_only: assert property (sda_dev_oe |-> !sda_dev_o)
    else $error("device drives data high");
  chk_host_pull_only: assert property (scl_oe |-> !scl_o)
    else $error("host drives clock high");
  chk_drive_clk_low: assert property ($rose(sda_dev_oe) |-> !scl_line)
    else $error("device takes data line while clock high");
  // data may only move while the clock is low
  chk_steady_clk_high: assert property (
    scl_line && $past(scl_line) |-> $stable(sda_dev_oe))
    else $error("device data changed while clock high");
  chk_one_talker: assert property (
    scl_line |-> !(sda_host_oe && sda_dev_oe))
    else $error("host and device drive data together");
  // the host never stalls here, so a long low hold is a lock-up
  chk_low_bounded: assert property (
    sda_dev_oe && !scl_line |-> ##[1:60] (scl_line || !sda_dev_oe))
    else $error("device holds data low too long");
  chk_clk_high_min: assert property ($rose(scl_line) |-> scl_line[*8])
    else $error("clock high phase too short");
endmodule : i2c_link_properties

// ### tb/tb.sv
// bench: host and target on one link; a second target under a bench
// bit-banger for bare reads, a bare stop and watchdog stalls
// assumes a 20 mhz clock and watchdog counts shortened to 20 / 200
`timescale 1ns/1ns
`include "i2c_target_map.svh"
module tb;
  localparam int WDT_S = 20;
  localparam int WDT_L = 200;
  // long enough that the normal gap alone cannot satisfy the suspend check
  localparam int GAP_S = 100;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic suspend = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [6:0] cmd_target = 7'h00;
  logic [7:0] cmd_ptr = 8'h00;
  logic [7:0] cmd_len = 8'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic a_sel = 1'b0;
  logic a_proto = 1'b1;
  logic load_wr = 1'b0;
  logic [7:0] load_addr = 8'h00;
  logic [7:0] load_data = 8'h00;
  logic b_scl = 1'b1;
  logic b_sda = 1'b1;
  logic a_sda_q = 1'b1;
  logic cmd_ready, rd_valid, done, nack, b_busy, b_en, b_sel, b_fire, b_wr;
  logic [7:0] rd_data, a_wd, b_wa, b_wd;
  logic [7:0] got [$];
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int stop_cyc = 0;
  int b_wr_n = 0;

  i2c_link_if link_a ();
  i2c_link_if link_b ();
  assign link_b.scl_o = 1'b0;
  assign link_b.scl_oe = ~b_scl;
  assign link_b.sda_host_o = 1'b0;
  assign link_b.sda_host_oe = ~b_sda;

  i2c_read_host #(.IDLE_SUSPEND_CYC(GAP_S)) i_i2c_read_host (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(link_a),
    .suspend_i(suspend), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
    .cmd_read_i(cmd_read), .cmd_target_i(cmd_target), .cmd_ptr_i(cmd_ptr),
    .cmd_wdata_i(cmd_wdata), .cmd_len_i(cmd_len), .rd_valid_o(rd_valid),
    .rd_data_o(rd_data), .done_o(done), .nack_o(nack));
  i2c_read_target #(.WDT_SHORT_CYC(WDT_S), .WDT_LONG_CYC(WDT_L))
    i_i2c_read_target (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(link_a),
    .address_select_output_pin_i(a_sel),
    .protocol_select_chip_select_pin_i(a_proto), .load_wr_i(load_wr),
    .load_addr_i(load_addr), .load_data_i(load_data), .reg_wr_o(),
    .reg_wr_addr_o(), .reg_wr_data_o(a_wd), .wdt_en_o(), .wdt_sel_o(),
    .wdt_reset_o(), .busy_o());
  i2c_read_target #(.WDT_SHORT_CYC(WDT_S), .WDT_LONG_CYC(WDT_L))
    i_i2c_read_target_b (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(link_b),
    .address_select_output_pin_i(1'b1),
    .protocol_select_chip_select_pin_i(1'b1), .load_wr_i(load_wr),
    .load_addr_i(load_addr), .load_data_i(load_data), .reg_wr_o(b_wr),
    .reg_wr_addr_o(b_wa), .reg_wr_data_o(b_wd), .wdt_en_o(b_en),
    .wdt_sel_o(b_sel), .wdt_reset_o(b_fire), .busy_o(b_busy));
  i2c_link_properties i_i2c_link_properties (.sys_clk_i(sys_clk_i),
    .rst_i(rst_i), .scl_o(link_a.scl_o), .scl_oe(link_a.scl_oe),
    .sda_host_oe(link_a.sda_host_oe), .sda_dev_o(link_a.sda_dev_o),
    .sda_dev_oe(link_a.sda_dev_oe), .scl_line(link_a.scl_line),
    .sda_line(link_a.sda_line));

  initial begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  // remember when the host last finished a stop, for the idle gap
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    a_sda_q <= link_a.sda_line;
    if (link_a.scl_line && link_a.sda_line && !a_sda_q) stop_cyc <= cyc;
    if (b_wr === 1'b1) b_wr_n <= b_wr_n + 1;
  end

  function automatic logic [7:0] pat(input logic [7:0] a);
    return a ^ 8'h5A;
  endfunction : pat

  task automatic check(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    if (err_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  // write data is the inverted pointer, so one argument covers both
  task automatic host_cmd(input logic rd, input logic [6:0] tgt,
    input logic [7:0] ptr, input logic [7:0] len);
    int n;
    got.delete();
    @(posedge sys_clk_i);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_target <= tgt;
    cmd_ptr <= ptr;
    cmd_wdata <= ~ptr;
    cmd_len <= len;
    @(posedge sys_clk_i);
    cmd_valid <= 1'b0;
    for (n = 0; n < 20000; n++) begin
      @(posedge sys_clk_i);
      #1;
      if (rd_valid === 1'b1) got.push_back(rd_data);
      if (done === 1'b1) break;
    end
    if (n == 20000) begin
      check("host done", 8'h00, 8'h01);
      end_of_test();
    end
  endtask : host_cmd

  task automatic bb_drive(input logic c, input logic d);
    @(posedge sys_clk_i);
    b_scl <= c;
    b_sda <= d;
    repeat (7) @(posedge sys_clk_i);
  endtask : bb_drive

  // clock low first, then data, so no edge looks like start or stop
  task automatic bb_bit(input logic d, output logic r);
    bb_drive(1'b0, b_sda);
    bb_drive(1'b0, d);
    bb_drive(1'b1, d);
    r = link_b.sda_line;
  endtask : bb_bit

  task automatic bb_cond(input logic s);
    bb_drive(1'b0, b_sda);
    bb_drive(1'b0, ~s);
    bb_drive(1'b1, ~s);
    bb_drive(1'b1, s);
  endtask : bb_cond

  task automatic bb_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bb_bit(d[i], ack);
    bb_bit(1'b1, ack);
  endtask : bb_byte

  task automatic bb_read(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bb_bit(1'b1, d[i]);
    bb_bit(last, r);
  endtask : bb_read

  task automatic bb_write(input logic [7:0] ptr, input logic [7:0] data);
    logic a;
    bb_cond(1'b0);
    bb_byte(8'hD2, a);
    check("address ack", a, 1'b0);
    bb_byte(ptr, a);
    check("pointer ack", a, 1'b0);
    bb_byte(data, a);
    check("data ack", a, 1'b0);
    bb_cond(1'b1);
    // idle after a write before the next access
    repeat (`IDLE_NORMAL_CYC) @(posedge sys_clk_i);
  endtask : bb_write

  task automatic bb_rd2(input logic [7:0] e0, input logic [7:0] e1);
    logic a;
    logic [7:0] d;
    bb_cond(1'b0);
    bb_byte(8'hD3, a);
    check("read address ack", a, 1'b0);
    bb_read(1'b0, d);
    check("first byte", d, e0);
    bb_read(1'b1, d);
    check("next byte", d, e1);
    bb_cond(1'b1);
  endtask : bb_rd2

  // stop the clock low right after the address, while the device acks
  task automatic bb_stall(input int lim, input logic fire);
    logic r;
    logic [7:0] ad;
    int n;
    ad = 8'hD2;
    bb_cond(1'b0);
    for (int i = 7; i >= 0; i--) bb_bit(ad[i], r);
    @(posedge sys_clk_i);
    b_scl <= 1'b0;
    b_sda <= 1'b1;
    for (n = 0; n < 400; n++) begin
      @(posedge sys_clk_i);
      #1;
      if (b_fire === 1'b1) break;
    end
    check("watchdog delay", n >= lim && n <= lim + 8, fire);
    @(posedge sys_clk_i);
    #1;
    check("data released", link_b.sda_line, fire);
    bb_drive(1'b1, 1'b1);
    bb_cond(1'b1);
  endtask : bb_stall

  initial begin
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 256; i++) begin
      @(posedge sys_clk_i);
      load_wr <= (i != 8'h70);
      load_addr <= i[7:0];
      load_data <= pat(i[7:0]);
    end
    @(posedge sys_clk_i);
    load_wr <= 1'b0;
    bb_drive(1'b1, 1'b0);
    bb_drive(1'b1, 1'b1);
    check("busy after bare stop", b_busy, 1'b1);
    bb_rd2(pat(8'h00), pat(8'h01));
    bb_write(8'h02, 8'h77);
    check("written address", b_wa, 8'h02);
    check("written data", b_wd, 8'h77);
    bb_rd2(8'h77, pat(8'h03));
    bb_rd2(8'h77, pat(8'h03));
    bb_write(8'h70, 8'h01);
    check("watchdog enable", b_en, 1'b1);
    check("period select", b_sel, 1'b0);
    bb_stall(WDT_S, 1'b1);
    bb_write(8'h70, 8'h03);
    check("period select", b_sel, 1'b1);
    bb_stall(WDT_L, 1'b1);
    bb_write(8'h70, 8'h00);
    check("watchdog enable", b_en, 1'b0);
    bb_stall(WDT_S, 1'b0);
    bb_rd2(8'h00, pat(8'h71));
    host_cmd(1'b1, 7'h68, 8'h70, 8'h01);
    check("config reset", got[0], 8'h00);
    host_cmd(1'b0, 7'h68, 8'h20, 8'h00);
    check("write refused", nack, 1'b0);
    check("written data", a_wd, 8'hDF);
    check("idle gap", cyc - stop_cyc >= `IDLE_NORMAL_CYC - 2, 1'b1);
    host_cmd(1'b1, 7'h68, 8'hFE, 8'h03);
    check("burst count", 8'(got.size()), 8'h03);
    for (int i = 0; i < 3; i++) begin
      check("burst byte", got[i], pat(8'hFE + i[7:0]));
    end
    host_cmd(1'b1, 7'h68, 8'h20, 8'h01);
    check("read back", got[0], 8'hDF);
    for (int s = 0; s < 2; s++) begin
      a_sel <= s[0];
      host_cmd(1'b0, 7'h69, 8'h21, 8'h00);
      check("select refusal", nack, !s[0]);
    end
    a_sel <= 1'b0;
    a_proto <= 1'b0;
    host_cmd(1'b0, 7'h68, 8'h22, 8'h00);
    check("other protocol refusal", nack, 1'b1);
    a_proto <= 1'b1;
    suspend <= 1'b1;
    host_cmd(1'b0, 7'h68, 8'h22, 8'h00);
    check("suspend gap", cyc - stop_cyc >= GAP_S - 2, 1'b1);
    check("write strobes", 8'(b_wr_n), 8'h04);
    end_of_test();
  end
endmodule : tb
